// ---- src/rmpu_pkg.sv ----
// Package: shared constants and carriers for the region protection unit
package rmpu_pkg;
	localparam int          NUM_REGIONS    = 8;
	localparam int          RIDX_W         = 3;
	localparam logic [31:0] SYS_SPACE_BASE = 32'he0000000;
	localparam logic [31:0] PPS_BASE       = 32'he0000000;
	localparam logic [31:0] PPS_LAST       = 32'he00fffff;
	localparam int          SIZE_MIN_N     = 5;
	localparam int          SUBREG_MIN_N   = 8;
	localparam logic [4:0]  SIZE_FIELD_MIN = 5'h04;
	// Register word offsets inside the unit's window
	localparam logic [3:0]  OFF_TYPE       = 4'h0;
	localparam logic [3:0]  OFF_CTRL       = 4'h1;
	localparam logic [3:0]  OFF_RNR        = 4'h2;
	localparam logic [3:0]  OFF_BASE       = 4'h3;
	localparam logic [3:0]  OFF_ATTR       = 4'h4;
	localparam logic [3:0]  OFF_ALIAS_LAST = 4'ha;
	// Control fields
	localparam int          CTRL_ENABLE    = 0;
	localparam int          CTRL_HFNMI     = 1;
	localparam int          CTRL_PRIVDEF   = 2;
	localparam logic [2:0]  CTRL_RESET     = 3'h0;
	// Base register fields
	localparam int          BASE_VALID     = 4;
	localparam int          BASE_ADDR_LSB  = 5;
	// Attribute register fields
	localparam int          ATTR_EN        = 0;
	localparam int          ATTR_SIZE_LSB  = 1;
	localparam int          ATTR_SRD_LSB   = 8;
	localparam int          ATTR_B         = 16;
	localparam int          ATTR_C         = 17;
	localparam int          ATTR_S         = 18;
	localparam int          ATTR_TEX_LSB   = 19;
	localparam int          ATTR_AP_LSB    = 24;
	localparam int          ATTR_XN        = 28;
	localparam logic [31:0] ATTR_RESET     = 32'h00000000;
	localparam logic [31:0] BASE_RESET     = 32'h00000000;
	// Memory types
	typedef enum logic [1:0] {
		RMPU_MT_STRONG = 2'h0,
		RMPU_MT_DEVICE = 2'h1,
		RMPU_MT_NORMAL = 2'h2
	} rmpu_mtype_e;

	typedef struct packed {
		logic [31:0] addr;
		logic        priv;
		logic        write;
		logic        ifetch;
		logic        vector_rd;
		logic        neg_prio;
	} rmpu_req_s;

	typedef struct packed {
		logic [31:0] addr;
		logic        fault;
		logic        xn;
		rmpu_mtype_e mtype;
		logic [4:0]  texcb;
		logic        shareable;
		logic        hit_region;
		logic [RIDX_W-1:0] region;
	} rmpu_rsp_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        priv;
		logic [3:0]  word;
		logic [31:0] wdata;
	} rmpu_reg_req_s;
endpackage : rmpu_pkg

// ---- src/rmpu_region_match.sv ----
// One region's address and sub-region match
`timescale 1ns/1ns
module rmpu_region_match (
	// Region state
	input  wire logic [31:0] base,
	input  wire logic [31:0] attr,
	// Access address
	input  wire logic [31:0] addr,
	// Result
	output logic             hit
);
	logic [4:0]  size_f;
	logic [5:0]  lsb;
	logic [31:0] mask;
	logic [2:0]  sub;
	always_comb begin
		size_f = attr[rmpu_pkg::ATTR_SIZE_LSB +: 5];
		lsb    = 6'(size_f) + 6'h01;
		mask   = (lsb >= 6'h20) ? 32'h00000000 : (32'hffffffff << lsb);
		sub    = (lsb >= 6'h20) ? addr[31:29] : 3'(addr >> (lsb - 6'h03));
		hit    = 1'b0;
		if (attr[rmpu_pkg::ATTR_EN] && size_f >= rmpu_pkg::SIZE_FIELD_MIN
		    && ((addr & mask) == (base & mask))) begin
			if (lsb >= 6'(rmpu_pkg::SUBREG_MIN_N))
				hit = !attr[rmpu_pkg::ATTR_SRD_LSB + 32'(sub)];
			else
				hit = 1'b1;
		end
	end
endmodule : rmpu_region_match

// ---- src/rmpu_top.sv ----
// Region memory protection unit: registers, region scan and permission check
// Function
// - Decide rights and attributes only; the address passes through unchanged.
// - Disabled unit gives default map attributes; enabled regions define the map.
// - Private peripheral space always bypasses regions and uses default map.
// - Vector table reads always use default map, never region checks.
// - Addresses at or above system space base are always execute-never.
// - Device system space may become strongly-ordered only, never normal.
// - Negative-priority handlers run with protection on or off per config bit.
// - Optional background default map for privileged accesses matching no region.
// - Overlapping matches use the highest numbered region.
// - Failed access condition, or no match without the privileged background map, raises a fault.
// - Regions cover both instruction fetches and data accesses.
// - Region base aligned to size; match compares only upper address bits.
// - Region size 2^N bytes with N from 5 to 32.
// - Regions of 256 bytes or more split into eight sub-regions.
// - Eight sub-region disable bits per region remove sub-regions from match.
// - Disabled sub-region falls to other regions, background, or fault.
// - Regions below 256 bytes have no sub-regions; software writes zero.
// - Base register write may select the region, for regions 0 to 7.
// - Base/attribute pair aliased three more times for multi-word store updates.
// - Region count is a parameter; all region state held in registers.
// - Denied fetch or data access raises protection fault exception.
// - Unprivileged register access raises a protection fault.
// - Each region has its own enable bit gating address matching.
`timescale 1ns/1ns
module rmpu_top (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Access check
	input  wire logic                  acc_valid,
	input  wire rmpu_pkg::rmpu_req_s   acc_req,
	output logic                       chk_valid,
	output rmpu_pkg::rmpu_rsp_s        chk_rsp,
	output logic                       protection_fault_exception,
	// Register port
	input  wire rmpu_pkg::rmpu_reg_req_s reg_req,
	output logic [31:0]                reg_rdata,
	output logic                       reg_fault
);
	localparam int N = rmpu_pkg::NUM_REGIONS;

	logic [2:0]                   ctrl_q;
	logic [rmpu_pkg::RIDX_W-1:0]  rnr_q;
	logic [31:0]                  base_q [N];
	logic [31:0]                  attr_q [N];
	logic [N-1:0]                 hits;

	// Default map: type for an address
	function automatic rmpu_pkg::rmpu_mtype_e dflt_type(input logic [31:0] a);
		if (a[31:29] == 3'h2 || a[31:29] == 3'h5 || a[31:29] == 3'h6
		    || a >= rmpu_pkg::SYS_SPACE_BASE)
			return (a >= rmpu_pkg::PPS_BASE && a <= rmpu_pkg::PPS_LAST)
			       ? rmpu_pkg::RMPU_MT_STRONG : rmpu_pkg::RMPU_MT_DEVICE;
		return rmpu_pkg::RMPU_MT_NORMAL;
	endfunction : dflt_type

	function automatic logic dflt_xn(input logic [31:0] a);
		return (a[31:28] > 4'h9) || (a[31:29] == 3'h2);
	endfunction : dflt_xn

	function automatic logic in_pps(input logic [31:0] a);
		return a >= rmpu_pkg::PPS_BASE && a <= rmpu_pkg::PPS_LAST;
	endfunction : in_pps

	// Register decode
	logic                         reg_ok;
	logic                         alias_wr;
	logic [1:0]                   alias_n;
	logic                         alias_is_attr;
	logic [rmpu_pkg::RIDX_W-1:0]  base_sel;
	logic [rmpu_pkg::RIDX_W-1:0]  tgt;
	logic [3:0]                   woff;
	always_comb begin
		reg_ok        = reg_req.valid && reg_req.priv;
		woff          = reg_req.word - rmpu_pkg::OFF_BASE;
		alias_wr      = reg_ok && reg_req.write && reg_req.word >= rmpu_pkg::OFF_BASE
		                && reg_req.word <= rmpu_pkg::OFF_ALIAS_LAST;
		alias_n       = woff[2:1];
		alias_is_attr = woff[0];
		base_sel      = rnr_q + rmpu_pkg::RIDX_W'(alias_n);
		if (!alias_is_attr && reg_req.wdata[rmpu_pkg::BASE_VALID])
			base_sel = reg_req.wdata[rmpu_pkg::RIDX_W-1:0];
		tgt = base_sel;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			ctrl_q <= rmpu_pkg::CTRL_RESET;
		else if (reg_ok && reg_req.write && reg_req.word == rmpu_pkg::OFF_CTRL)
			ctrl_q <= reg_req.wdata[2:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			rnr_q <= '0;
		else if (reg_ok && reg_req.write && reg_req.word == rmpu_pkg::OFF_RNR)
			rnr_q <= reg_req.wdata[rmpu_pkg::RIDX_W-1:0];
		else if (alias_wr && !alias_is_attr && reg_req.wdata[rmpu_pkg::BASE_VALID])
			rnr_q <= reg_req.wdata[rmpu_pkg::RIDX_W-1:0];
	end

	// Region state in flops, count set by parameter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				base_q[i] <= rmpu_pkg::BASE_RESET;
				attr_q[i] <= rmpu_pkg::ATTR_RESET;
			end
		end else if (alias_wr) begin
			if (alias_is_attr)
				attr_q[tgt] <= reg_req.wdata;
			else
				base_q[tgt] <= {reg_req.wdata[31:rmpu_pkg::BASE_ADDR_LSB], 5'h00};
		end
	end

	// Register read data and access fault
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
			reg_fault <= 1'b0;
		end else begin
			reg_fault <= reg_req.valid && !reg_req.priv;
			reg_rdata <= '0;
			if (reg_ok && !reg_req.write) begin
				unique case (reg_req.word)
					rmpu_pkg::OFF_TYPE: reg_rdata <= {16'h0000, 8'(N), 8'h00};
					rmpu_pkg::OFF_CTRL: reg_rdata <= {29'h0, ctrl_q};
					rmpu_pkg::OFF_RNR:  reg_rdata <= 32'(rnr_q);
					rmpu_pkg::OFF_BASE: reg_rdata <= base_q[rnr_q] | 32'(rnr_q);
					rmpu_pkg::OFF_ATTR: reg_rdata <= attr_q[rnr_q];
					default:            reg_rdata <= '0;
				endcase
			end
		end
	end

	// Region matchers, shared by fetch and data
	for (genvar g = 0; g < N; g++) begin : g_match
		rmpu_region_match u_match (
			.base (base_q[g]),
			.attr (attr_q[g]),
			.addr (acc_req.addr),
			.hit  (hits[g])
		);
		AST_EN_GATE: assert property (@(posedge clk) disable iff (!rst_n)
			hits[g] |-> attr_q[g][rmpu_pkg::ATTR_EN])
			else $error("disabled region matched");
	end

	// Combinational decision
	logic                        use_dflt;
	logic                        found;
	logic [rmpu_pkg::RIDX_W-1:0] sel;
	logic [31:0]                 sattr;
	logic [2:0]                  ap;
	logic                        xn;
	logic                        perm_ok;
	logic                        no_map;
	rmpu_pkg::rmpu_mtype_e       mt;
	logic [4:0]                  texcb;
	logic                        sys;
	always_comb begin
		sys      = acc_req.addr >= rmpu_pkg::SYS_SPACE_BASE;
		use_dflt = acc_req.vector_rd || in_pps(acc_req.addr)
		           || !ctrl_q[rmpu_pkg::CTRL_ENABLE]
		           || (acc_req.neg_prio && !ctrl_q[rmpu_pkg::CTRL_HFNMI]);
		found = 1'b0;
		sel   = '0;
		for (int i = 0; i < N; i++) begin
			if (hits[i]) begin
				found = 1'b1;
				sel   = rmpu_pkg::RIDX_W'(i);
			end
		end
		sattr  = attr_q[sel];
		texcb  = {sattr[rmpu_pkg::ATTR_TEX_LSB +: 3], sattr[rmpu_pkg::ATTR_C],
		          sattr[rmpu_pkg::ATTR_B]};
		no_map = 1'b0;
		mt     = dflt_type(acc_req.addr);
		ap     = 3'h3;
		xn     = dflt_xn(acc_req.addr);
		if (!use_dflt) begin
			if (found) begin
				ap = sattr[rmpu_pkg::ATTR_AP_LSB +: 3];
				xn = sattr[rmpu_pkg::ATTR_XN];
				if (texcb == 5'h00)
					mt = rmpu_pkg::RMPU_MT_STRONG;
				else if (texcb == 5'h01 || texcb == 5'h10)
					mt = rmpu_pkg::RMPU_MT_DEVICE;
				else
					mt = rmpu_pkg::RMPU_MT_NORMAL;
				if (sys && mt == rmpu_pkg::RMPU_MT_NORMAL)
					mt = dflt_type(acc_req.addr);
				if (sys && dflt_type(acc_req.addr) == rmpu_pkg::RMPU_MT_DEVICE
				    && mt != rmpu_pkg::RMPU_MT_STRONG)
					mt = rmpu_pkg::RMPU_MT_DEVICE;
			end else if (ctrl_q[rmpu_pkg::CTRL_PRIVDEF] && acc_req.priv) begin
				ap = 3'h1;
			end else begin
				no_map = 1'b1;
			end
		end
		if (sys)
			xn = 1'b1;
		// Permission check against privilege, direction and fetch
		unique case (ap)
			3'h1:    perm_ok = acc_req.priv;
			3'h2:    perm_ok = acc_req.priv || !acc_req.write;
			3'h3:    perm_ok = 1'b1;
			3'h5:    perm_ok = acc_req.priv && !acc_req.write;
			3'h6,
			3'h7:    perm_ok = !acc_req.write;
			default: perm_ok = 1'b0;
		endcase
		if (acc_req.ifetch && xn)
			perm_ok = 1'b0;
		if (use_dflt && !acc_req.ifetch)
			perm_ok = 1'b1;
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chk_valid                  <= 1'b0;
			chk_rsp                    <= '0;
			protection_fault_exception <= 1'b0;
		end else begin
			chk_valid                  <= acc_valid;
			chk_rsp.addr               <= acc_req.addr;
			chk_rsp.fault              <= no_map || !perm_ok;
			chk_rsp.xn                 <= xn;
			chk_rsp.mtype              <= mt;
			chk_rsp.texcb              <= use_dflt ? 5'h00 : texcb;
			chk_rsp.shareable          <= !use_dflt && found && sattr[rmpu_pkg::ATTR_S];
			chk_rsp.hit_region         <= !use_dflt && found;
			chk_rsp.region             <= sel;
			protection_fault_exception <= (acc_valid && (no_map || !perm_ok))
			                              || (reg_req.valid && !reg_req.priv);
		end
	end

	// Assertions
	AST_ADDR_PASS: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid |=> chk_rsp.addr == $past(acc_req.addr))
		else $error("address changed");
	AST_SYS_XN: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_req.addr >= rmpu_pkg::SYS_SPACE_BASE |=> chk_rsp.xn)
		else $error("system space not execute-never");
	AST_SYS_NOT_NORMAL: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_req.addr >= rmpu_pkg::SYS_SPACE_BASE
		|=> chk_rsp.mtype != rmpu_pkg::RMPU_MT_NORMAL)
		else $error("system space mapped normal");
	AST_PPS_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && in_pps(acc_req.addr) |=> !chk_rsp.hit_region)
		else $error("private space used region");
	AST_PPS_DFLT: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && in_pps(acc_req.addr) && !acc_req.ifetch
		|=> !chk_rsp.fault && chk_rsp.mtype == rmpu_pkg::RMPU_MT_STRONG)
		else $error("private space left default map");
	AST_VEC_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_req.vector_rd |=> !chk_rsp.hit_region && !chk_rsp.fault)
		else $error("vector read checked");
	AST_DIS_DEFAULT: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && !ctrl_q[rmpu_pkg::CTRL_ENABLE] && !acc_req.ifetch
		|=> !chk_rsp.fault && !chk_rsp.hit_region)
		else $error("disabled unit faulted");
	AST_FAULT_EXC: assert property (@(posedge clk) disable iff (!rst_n)
		chk_valid && chk_rsp.fault |-> protection_fault_exception)
		else $error("fault without exception");
	AST_UNPRIV_REG: assert property (@(posedge clk) disable iff (!rst_n)
		reg_req.valid && !reg_req.priv |=> reg_fault && protection_fault_exception
		&& $stable(ctrl_q))
		else $error("unprivileged register access not faulted");
	AST_UNPRIV_RD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		reg_req.valid && !reg_req.priv |=> reg_rdata == '0 && $stable(rnr_q))
		else $error("unprivileged register access took effect");
	AST_HIGHEST: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && !use_dflt && hits[N-1] |=> chk_rsp.region == rmpu_pkg::RIDX_W'(N - 1))
		else $error("not highest region");
	AST_NO_MAP: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && !use_dflt && hits == '0 && !(ctrl_q[rmpu_pkg::CTRL_PRIVDEF] && acc_req.priv)
		|=> chk_rsp.fault)
		else $error("unmapped access not faulted");
	AST_BACKGROUND: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && !use_dflt && hits == '0 && ctrl_q[rmpu_pkg::CTRL_PRIVDEF]
		&& acc_req.priv && !acc_req.ifetch |=> !chk_rsp.fault && !chk_rsp.hit_region)
		else $error("background map refused privileged access");
	AST_IFETCH_XN: assert property (@(posedge clk) disable iff (!rst_n)
		acc_valid && acc_req.ifetch && xn |=> chk_rsp.fault && protection_fault_exception)
		else $error("fetch from execute-never allowed");

	// Register writes, each built on a decoded request sequence
	sequence s_ctrl_wr;
		reg_ok && reg_req.write && reg_req.word == rmpu_pkg::OFF_CTRL;
	endsequence
	sequence s_attr_wr;
		alias_wr && alias_is_attr;
	endsequence
	sequence s_base_sel;
		alias_wr && !alias_is_attr && reg_req.wdata[rmpu_pkg::BASE_VALID];
	endsequence
	AST_CTRL_WR: assert property (@(posedge clk) disable iff (!rst_n)
		s_ctrl_wr |=> ctrl_q == 3'($past(reg_req.wdata)))
		else $error("control write lost");
	AST_ATTR_WR: assert property (@(posedge clk) disable iff (!rst_n)
		s_attr_wr |=> attr_q[$past(tgt)] == $past(reg_req.wdata))
		else $error("attribute write missed its region");
	AST_BASE_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		s_base_sel |=> rnr_q == rmpu_pkg::RIDX_W'($past(reg_req.wdata)))
		else $error("base write did not select region");
endmodule : rmpu_top

// ---- sim/rmpu_core_model.sv ----
// Core-side model: issues one access at a time and captures the check result
`timescale 1ns/1ns
module rmpu_core_model (
	// Clock
	input  wire logic                clk,
	// Access request
	output logic                     acc_valid,
	output rmpu_pkg::rmpu_req_s      acc_req,
	// Check result
	input  wire logic                chk_valid,
	input  wire rmpu_pkg::rmpu_rsp_s chk_rsp,
	input  wire logic                fault_pulse
);
	initial begin
		acc_valid = 1'b0;
		acc_req   = '0;
	end

	task issue(input rmpu_pkg::rmpu_req_s r, output rmpu_pkg::rmpu_rsp_s rsp,
		output logic vld, output logic exc);
		@(posedge clk);
		acc_valid <= 1'b1;
		acc_req   <= r;
		@(posedge clk);
		// Released lines show the inverse so a stale address never looks valid
		acc_valid <= 1'b0;
		acc_req   <= ~r;
		#1;
		vld = chk_valid;
		rsp = chk_rsp;
		exc = fault_pulse;
	endtask : issue
endmodule : rmpu_core_model

// ---- sim/rmpu_top_tb.sv ----
// Testbench for the region protection unit: register tasks and access scenarios
`timescale 1ns/1ns
`define RMPU_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module rmpu_top_tb;
	localparam logic [4:0] PR = 5'h10;
	localparam logic [4:0] WR = 5'h08;
	localparam logic [4:0] IF = 5'h04;
	localparam logic [4:0] VEC = 5'h02;
	localparam logic [4:0] NEG = 5'h01;
	logic                    clk;
	logic                    rst_n;
	logic                    acc_valid;
	rmpu_pkg::rmpu_req_s     acc_req;
	logic                    chk_valid;
	rmpu_pkg::rmpu_rsp_s     chk_rsp;
	logic                    pfe;
	rmpu_pkg::rmpu_reg_req_s reg_req;
	logic [31:0]             reg_rdata;
	logic                    reg_fault;
	int                      error_cnt;
	int                      checks_done;
	logic [31:0]             rd;
	logic                    rf;
	logic                    re;
	rmpu_pkg::rmpu_rsp_s     rsp;
	logic                    rv;
	logic                    rx;

	rmpu_top dut (.clk(clk), .rst_n(rst_n), .acc_valid(acc_valid), .acc_req(acc_req),
		.chk_valid(chk_valid), .chk_rsp(chk_rsp), .protection_fault_exception(pfe),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_fault(reg_fault));
	rmpu_core_model core (.clk(clk), .acc_valid(acc_valid), .acc_req(acc_req),
		.chk_valid(chk_valid), .chk_rsp(chk_rsp), .fault_pulse(pfe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task finish_test;
		$display("errors=%0d checks=%0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	task reg_op(input logic w, input logic p, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_req <= {1'b1, w, p, a, d};
		@(posedge clk);
		reg_req <= {1'b0, ~w, p, ~a, ~d};
		#1;
		rd = reg_rdata;
		rf = reg_fault;
		re = pfe;
	endtask : reg_op

	task acc(input logic [31:0] a, input logic [4:0] f);
		core.issue({a, f}, rsp, rv, rx);
	endtask : acc

	// Size field holds log2(size)-1; only B and C are used for the type
	function automatic logic [31:0] mk_attr(input int n, input logic [7:0] srd,
		input logic [2:0] ap, input logic xn, input logic [1:0] cb);
		mk_attr = 32'h1 | (32'(n - 1) << rmpu_pkg::ATTR_SIZE_LSB)
			| (32'(srd) << rmpu_pkg::ATTR_SRD_LSB) | (32'(ap) << rmpu_pkg::ATTR_AP_LSB)
			| (32'(xn) << rmpu_pkg::ATTR_XN) | (32'(cb) << rmpu_pkg::ATTR_B);
	endfunction : mk_attr

	task set_region(input logic [2:0] idx, input logic [31:0] base, input logic [31:0] attr);
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_BASE, base | (32'h1 << rmpu_pkg::BASE_VALID) | idx);
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_ATTR, attr);
	endtask : set_region

	initial begin
		#40000;
		error_cnt++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		reg_req = '0;
		error_cnt = 0;
		checks_done = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		reg_op(1'b0, 1'b1, rmpu_pkg::OFF_CTRL, 32'h0);
		`RMPU_CHK(rd, 32'h0)
		reg_op(1'b0, 1'b1, rmpu_pkg::OFF_TYPE, 32'h0);
		`RMPU_CHK(rd[15:8], 8'(rmpu_pkg::NUM_REGIONS))
		reg_op(1'b0, 1'b1, 4'hf, 32'h0);
		`RMPU_CHK(rd, 32'h0)
		// Unit off: default map, address untouched
		acc(32'h2000_0040, WR);
		`RMPU_CHK({rv, rsp.fault, rsp.addr}, {2'b10, 32'h2000_0040})
		acc(32'he000_1000, PR | IF);
		`RMPU_CHK({rsp.fault, rsp.xn}, 2'b11)
		reg_op(1'b1, 1'b0, rmpu_pkg::OFF_CTRL, 32'h1);
		`RMPU_CHK({rf, re}, 2'b11)
		reg_op(1'b0, 1'b1, rmpu_pkg::OFF_CTRL, 32'h0);
		`RMPU_CHK(rd, 32'h0)
		// On, no regions, no background
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_CTRL, 32'h1);
		acc(32'h2000_0040, PR);
		`RMPU_CHK({rsp.fault, rx}, 2'b11)
		acc(32'he000_0100, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b0)
		acc(32'h0000_0008, VEC);
		`RMPU_CHK(rsp.fault, 1'b0)
		acc(32'h3000_0000, NEG);
		`RMPU_CHK(rsp.fault, 1'b0)
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_CTRL, 32'h3);
		acc(32'h3000_0000, NEG);
		`RMPU_CHK(rsp.fault, 1'b1)
		set_region(3'h0, 32'h2000_0000, mk_attr(12, 8'h00, 3'h3, 1'b0, 2'h0));
		acc(32'h2000_0ffc, WR);
		`RMPU_CHK({rsp.fault, rsp.hit_region, rsp.region}, {2'b01, 3'h0})
		acc(32'h2000_1000, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h2000_0100, IF);
		`RMPU_CHK(rsp.fault, 1'b0)
		set_region(3'h1, 32'h2000_0000, mk_attr(8, 8'h00, 3'h3, 1'b1, 2'h0));
		acc(32'h2000_00f0, IF);
		`RMPU_CHK({rsp.fault, rsp.region}, {1'b1, 3'h1})
		set_region(3'h1, 32'h2000_0000, mk_attr(8, 8'h00, 3'h1, 1'b0, 2'h0));
		acc(32'h2000_00f0, WR);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h2000_00f0, PR | WR);
		`RMPU_CHK(rsp.fault, 1'b0)
		set_region(3'h2, 32'h2000_0800, mk_attr(5, 8'h00, 3'h3, 1'b0, 2'h0));
		acc(32'h2000_081f, 5'h0);
		`RMPU_CHK(rsp.region, 3'h2)
		acc(32'h2000_0820, 5'h0);
		`RMPU_CHK(rsp.region, 3'h0)
		// Sub-region 1 of region 0 (512 bytes at 0x200) removed
		set_region(3'h0, 32'h2000_0000, mk_attr(12, 8'h02, 3'h3, 1'b0, 2'h0));
		acc(32'h2000_0200, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h2000_0400, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b0)
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_CTRL, 32'h5);
		acc(32'h2000_0200, PR);
		`RMPU_CHK({rsp.fault, rsp.hit_region}, 2'b00)
		acc(32'h2000_0200, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b1)
		set_region(3'h3, 32'h4000_0000, mk_attr(10, 8'h00, 3'h3, 1'b0, 2'h0) & ~32'h1);
		acc(32'h4000_0000, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b1)
		set_region(3'h4, 32'he010_0000, mk_attr(20, 8'h00, 3'h3, 1'b0, 2'h3));
		acc(32'he010_0000, PR);
		`RMPU_CHK({rsp.mtype, rsp.xn}, {rmpu_pkg::RMPU_MT_DEVICE, 1'b1})
		`RMPU_CHK({rsp.texcb, rsp.hit_region, rsp.region}, {5'h03, 1'b1, 3'h4})
		// Aliases relative to region number 4
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_RNR, 32'h4);
		reg_op(1'b1, 1'b1, 4'h5, 32'h5000_0000);
		reg_op(1'b1, 1'b1, 4'h6, mk_attr(10, 8'h00, 3'h3, 1'b0, 2'h0));
		reg_op(1'b1, 1'b1, 4'h9, 32'h6000_0000);
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_ALIAS_LAST, mk_attr(10, 8'h00, 3'h3, 1'b0, 2'h0));
		acc(32'h5000_0010, 5'h0);
		`RMPU_CHK({rsp.fault, rsp.region}, {1'b0, 3'h5})
		acc(32'h6000_0010, 5'h0);
		`RMPU_CHK({rsp.fault, rsp.region}, {1'b0, 3'h7})
		reg_op(1'b1, 1'b1, rmpu_pkg::OFF_RNR, 32'h7);
		reg_op(1'b0, 1'b1, rmpu_pkg::OFF_ATTR, 32'h0);
		`RMPU_CHK(rd, mk_attr(10, 8'h00, 3'h3, 1'b0, 2'h0))
		// Shareable device region, then permission codes 2, 6, 5 and 0
		set_region(3'h6, 32'h7000_0000, mk_attr(10, 8'h00, 3'h2, 1'b0, 2'h1) | 32'h0004_0000);
		acc(32'h7000_0004, 5'h0);
		`RMPU_CHK({rsp.fault, rsp.mtype, rsp.shareable}, {1'b0, rmpu_pkg::RMPU_MT_DEVICE, 1'b1})
		`RMPU_CHK(rsp.texcb, 5'h01)
		acc(32'h7000_0004, WR);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h7000_0004, PR | WR);
		`RMPU_CHK(rsp.fault, 1'b0)
		set_region(3'h6, 32'h7000_0000, mk_attr(10, 8'h00, 3'h6, 1'b0, 2'h0));
		acc(32'h7000_0004, PR | WR);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h7000_0004, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b0)
		set_region(3'h6, 32'h7000_0000, mk_attr(10, 8'h00, 3'h5, 1'b0, 2'h0));
		acc(32'h7000_0004, 5'h0);
		`RMPU_CHK(rsp.fault, 1'b1)
		acc(32'h7000_0004, PR);
		`RMPU_CHK(rsp.fault, 1'b0)
		set_region(3'h6, 32'h7000_0000, mk_attr(10, 8'h00, 3'h0, 1'b0, 2'h0));
		acc(32'h7000_0004, PR);
		`RMPU_CHK(rsp.fault, 1'b1)
		finish_test();
	end
endmodule : rmpu_top_tb
